// [hdl/wpc_pkg.sv]
/*
  Package for the watchpoint comparator control block: register offsets,
  field positions, action codes, bus-access kinds and carrier structs.
  Assumes a 32-bit Avalon-MM word-addressed register slave.
*/
package wpc_pkg;
  localparam int unsigned WPC_AW = 4;
  // Word indices (byte address / 4)
  localparam logic [3:0] WPC_OFF_COMP0 = 4'h0;
  localparam logic [3:0] WPC_OFF_CTRL0 = 4'h1;
  localparam logic [3:0] WPC_OFF_COMP1 = 4'h2;
  localparam logic [3:0] WPC_OFF_MASK1 = 4'h3;
  localparam logic [3:0] WPC_OFF_CTRL1 = 4'h4;
  localparam logic [3:0] WPC_OFF_IRQ_STATUS = 4'h5;
  localparam logic [3:0] WPC_OFF_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] WPC_OFF_IRQ_CLEAR = 4'h7;
  // Control field positions
  localparam int unsigned WPC_ACT_LSB = 0;
  localparam int unsigned WPC_VCE_BIT = 8;
  localparam int unsigned WPC_VSZ_LSB = 10;
  localparam int unsigned WPC_LNK_LSB = 12;
  localparam int unsigned WPC_MATCH_BIT = 24;
  localparam logic [4:0] WPC_MASK_W = 5'h1f;
  // Action select codes
  localparam logic [3:0] WPC_ACT_OFF = 4'h0;
  localparam logic [3:0] WPC_ACT_FETCH = 4'h4;
  localparam logic [3:0] WPC_ACT_RD = 4'h5;
  localparam logic [3:0] WPC_ACT_WR = 4'h6;
  localparam logic [3:0] WPC_ACT_RW = 4'h7;
  // Value compare sizes
  localparam logic [1:0] WPC_SZ_BYTE = 2'h0;
  localparam logic [1:0] WPC_SZ_HALF = 2'h1;
  localparam logic [1:0] WPC_SZ_WORD = 2'h2;
  localparam logic [31:0] WPC_RESET_WORD = 32'h0;

  typedef enum logic [1:0] {WPC_KIND_FETCH, WPC_KIND_READ, WPC_KIND_WRITE} wpc_kind_t;

  // Observed processor access
  typedef struct packed {
    logic valid;
    wpc_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
  } wpc_access_t;

  // Comparator control fields held in flops
  typedef struct packed {
    logic [3:0] action;
    logic value_compare_enable;
    logic [1:0] value_compare_size;
    logic linked_comparator_index;
  } wpc_ctrl_t;
endpackage

// [hdl/wpc_cmp.sv]
/*
  One comparator's match decision: access-kind select, address compare with
  ignore mask and optional sized data compare. Purely combinational.
  Assumes access fields are stable while valid is high.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_cmp
  import wpc_pkg::*;
(
  input wire wpc_access_t acc_i,
  input wire logic [3:0] action_i,
  input wire logic [31:0] value_i,
  input wire logic [31:0] addr_mask_i,
  input wire logic data_mode_i,
  input wire logic [1:0] size_i,
  output logic kind_hit_o,
  output logic addr_hit_o,
  output logic data_hit_o
);
  logic [31:0] size_mask;

  always_comb begin
    unique case (action_i) // [RL3]
      WPC_ACT_FETCH: kind_hit_o = acc_i.valid && acc_i.kind == WPC_KIND_FETCH;
      WPC_ACT_RD: kind_hit_o = acc_i.valid && acc_i.kind == WPC_KIND_READ;
      WPC_ACT_WR: kind_hit_o = acc_i.valid && acc_i.kind == WPC_KIND_WRITE;
      WPC_ACT_RW: kind_hit_o = acc_i.valid && acc_i.kind != WPC_KIND_FETCH;
      // Off and undefined codes never match; undefined behaviour is left to software [RL11] [RL4]
      default: kind_hit_o = 1'b0;
    endcase
    unique case (size_i) // [RL10]
      WPC_SZ_BYTE: size_mask = 32'h0000_00ff;
      WPC_SZ_HALF: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
    addr_hit_o = ((acc_i.addr ^ value_i) & ~addr_mask_i) == 32'h0; // [RL6]
    data_hit_o = data_mode_i && (((acc_i.data ^ value_i) & size_mask) == 32'h0);
  end
endmodule // wpc_cmp
`default_nettype wire

// [hdl/wpc_top.sv]
/*
  Watchpoint comparator control: two comparators watching processor bus
  accesses, Avalon-MM register slave, sticky match flags cleared on read,
  and a level interrupt. Assumes one clock domain and a synchronous access feed.
*/
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RL1] Comparator zero compares data when value compare enable set, else address.
// [RL2] Reserved control bits always read back as zero.
// [RL3] Action code selects fetch, read, write, read-or-write or disabled.
// [RL4] Software uses only the five defined action codes.
// [RL5] Software sets comparator one action to zero when it supplies linked address.
// [RL6] Linked mode applies comparator one ignore mask for range matching.
// [RL7] Comparator one value-compare fields read zero and ignore writes.
// [RL8] Match flag sets on a selected match and clears when its control is read.
// [RL9] Linked comparator index picks which comparator supplies the linked address.
// [RL10] Value compare size selects byte, halfword or word data comparison.
// [RL11] Disabled comparator never sets its match flag.
module wpc_top
  import wpc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [WPC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire wpc_access_t acc_i,
  output logic [1:0] match_pulse_o,
  output logic irq_o
);
  logic [31:0] comp0, comp1, mask1;
  wpc_ctrl_t ctrl0, ctrl1;
  logic [1:0] match_seen_flag, irq_status, irq_enable;
  logic ack;
  logic [31:0] next_comp0, next_comp1, next_mask1;
  wpc_ctrl_t next_ctrl0, next_ctrl1;
  logic [1:0] next_match_seen_flag, next_irq_status, next_irq_enable, next_match_pulse;
  logic next_ack, next_irq;
  logic [31:0] next_readdata;
  logic [1:0] next_response;
  logic [31:0] be_mask, mask1_eff;
  logic k0, a0, d0, k1, a1;
  logic hit0, hit1, rd_req, wr_req;

  wpc_cmp u_cmp0 (
    .acc_i(acc_i), .action_i(ctrl0.action), .value_i(comp0), .addr_mask_i(32'h0), // [RL3]
    .data_mode_i(ctrl0.value_compare_enable), .size_i(ctrl0.value_compare_size), // [RL10]
    .kind_hit_o(k0), .addr_hit_o(a0), .data_hit_o(d0)
  );
  wpc_cmp u_cmp1 (
    .acc_i(acc_i), .action_i(ctrl1.action), .value_i(comp1), .addr_mask_i(mask1_eff),
    .data_mode_i(1'b0), .size_i(WPC_SZ_WORD),
    .kind_hit_o(k1), .addr_hit_o(a1), .data_hit_o()
  );

  always_comb begin
    mask1_eff = '0;
    for (int i = 0; i < 32; i++) begin
      mask1_eff[i] = (5'(i) < mask1[4:0]);
    end
    be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    rd_req = avs_read_i && !ack;
    wr_req = avs_write_i && !ack;
    // Data mode: index 1 pairs data with comparator one's masked address [RL1] [RL9] [RL6]
    if (ctrl0.value_compare_enable) begin
      hit0 = k0 && d0 && (!ctrl0.linked_comparator_index || a1);
    end else begin
      hit0 = k0 && a0;
    end
    hit1 = k1 && a1; // [RL11]
  end

  // Register bus state
  always_comb begin
    next_comp0 = comp0;
    next_comp1 = comp1;
    next_mask1 = mask1;
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_irq_enable = irq_enable;
    next_ack = rd_req || wr_req;
    next_readdata = avs_readdata_o;
    next_response = 2'h0;
    if (wr_req) begin
      unique case (avs_address_i)
        WPC_OFF_COMP0: next_comp0 = (comp0 & ~be_mask) | (avs_writedata_i & be_mask);
        WPC_OFF_COMP1: next_comp1 = (comp1 & ~be_mask) | (avs_writedata_i & be_mask);
        WPC_OFF_MASK1: if (avs_byteenable_i[0]) next_mask1 = {27'h0, avs_writedata_i[4:0] & WPC_MASK_W};
        WPC_OFF_CTRL0: begin
          if (avs_byteenable_i[0]) next_ctrl0.action = avs_writedata_i[WPC_ACT_LSB+:4];
          if (avs_byteenable_i[1]) begin
            next_ctrl0.value_compare_enable = avs_writedata_i[WPC_VCE_BIT];
            next_ctrl0.value_compare_size = avs_writedata_i[WPC_VSZ_LSB+:2];
            // Index held to one bit: only two comparators exist [RL9]
            next_ctrl0.linked_comparator_index = avs_writedata_i[WPC_LNK_LSB];
          end
        end
        WPC_OFF_CTRL1: if (avs_byteenable_i[0]) next_ctrl1.action = avs_writedata_i[WPC_ACT_LSB+:4]; // [RL7]
        WPC_OFF_IRQ_ENABLE: if (avs_byteenable_i[0]) next_irq_enable = avs_writedata_i[1:0];
        WPC_OFF_IRQ_STATUS, WPC_OFF_IRQ_CLEAR: ;
        default: next_response = 2'h2;
      endcase
    end
    if (rd_req) begin
      next_readdata = WPC_RESET_WORD; // [RL2]
      unique case (avs_address_i)
        WPC_OFF_COMP0: next_readdata = comp0;
        WPC_OFF_COMP1: next_readdata = comp1;
        WPC_OFF_MASK1: next_readdata = mask1;
        WPC_OFF_CTRL0: begin
          next_readdata[WPC_ACT_LSB+:4] = ctrl0.action;
          next_readdata[WPC_VCE_BIT] = ctrl0.value_compare_enable;
          next_readdata[WPC_VSZ_LSB+:2] = ctrl0.value_compare_size;
          next_readdata[WPC_LNK_LSB] = ctrl0.linked_comparator_index;
          next_readdata[WPC_MATCH_BIT] = match_seen_flag[0]; // [RL8]
        end
        WPC_OFF_CTRL1: begin
          next_readdata[WPC_ACT_LSB+:4] = ctrl1.action; // [RL7]
          next_readdata[WPC_MATCH_BIT] = match_seen_flag[1]; // [RL8]
        end
        WPC_OFF_IRQ_STATUS: next_readdata[1:0] = irq_status;
        WPC_OFF_IRQ_ENABLE: next_readdata[1:0] = irq_enable;
        WPC_OFF_IRQ_CLEAR: ;
        default: next_response = 2'h2;
      endcase
    end
  end

  // Match and interrupt state; a hit in the clearing cycle wins so no event is lost
  always_comb begin
    next_match_seen_flag = match_seen_flag;
    next_irq_status = irq_status;
    if (rd_req && avs_address_i == WPC_OFF_CTRL0) next_match_seen_flag[0] = 1'b0; // [RL8]
    if (rd_req && avs_address_i == WPC_OFF_CTRL1) next_match_seen_flag[1] = 1'b0; // [RL8]
    if (wr_req && avs_address_i == WPC_OFF_IRQ_CLEAR && avs_byteenable_i[0]) begin
      next_irq_status = irq_status & ~avs_writedata_i[1:0];
    end
    next_match_pulse = {hit1, hit0};
    next_match_seen_flag = next_match_seen_flag | next_match_pulse; // [RL8]
    next_irq_status = next_irq_status | next_match_pulse;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comp0 <= WPC_RESET_WORD;
      comp1 <= WPC_RESET_WORD;
      mask1 <= WPC_RESET_WORD;
      ctrl0 <= '0;
      ctrl1 <= '0;
      irq_enable <= 2'h0;
      ack <= 1'b0;
      avs_readdata_o <= WPC_RESET_WORD;
      avs_response_o <= 2'h0;
      match_seen_flag <= 2'h0;
      irq_status <= 2'h0;
      match_pulse_o <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      comp0 <= next_comp0;
      comp1 <= next_comp1;
      mask1 <= next_mask1;
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      irq_enable <= next_irq_enable;
      ack <= next_ack;
      avs_readdata_o <= next_readdata;
      avs_response_o <= next_response;
      match_seen_flag <= next_match_seen_flag;
      irq_status <= next_irq_status;
      match_pulse_o <= next_match_pulse;
      irq_o <= next_irq;
    end
  end

  // Waitrequest is high except in the single answer cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) avs_waitrequest_o <= 1'b1;
    else avs_waitrequest_o <= !next_ack;
  end

  property ctrl_read_clears_p(int idx, logic [3:0] off);
    @(posedge mclk_i) disable iff (!rstn_i)
      (rd_req && avs_address_i == off && !match_pulse_o[idx] && !next_match_pulse[idx]) |=> !match_seen_flag[idx];
  endproperty
  clear_on_read0_a: assert property (ctrl_read_clears_p(0, WPC_OFF_CTRL0)) else $error("flag 0 not cleared"); // [RL8]
  clear_on_read1_a: assert property (ctrl_read_clears_p(1, WPC_OFF_CTRL1)) else $error("flag 1 not cleared"); // [RL8]
  hit_sets_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL8]
    hit0 |=> match_seen_flag[0] && match_pulse_o[0]) else $error("hit lost");
  disabled_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL11]
    ctrl1.action == WPC_ACT_OFF |-> !hit1) else $error("disabled comparator hit");
  kind_select_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL3]
    (ctrl1.action == WPC_ACT_WR && acc_i.kind != WPC_KIND_WRITE) |-> !hit1)
    else $error("wrong access kind hit");
  addr_mode_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL1]
    (!ctrl0.value_compare_enable && ctrl0.action == WPC_ACT_FETCH && acc_i.valid
     && acc_i.kind == WPC_KIND_FETCH && acc_i.addr == comp0) |=> match_pulse_o[0]) else $error("address miss");
  size_byte_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL10]
    (ctrl0.value_compare_enable && !ctrl0.linked_comparator_index && ctrl0.value_compare_size == WPC_SZ_BYTE
     && k0 && acc_i.data[7:0] == comp0[7:0]) |-> hit0)
    else $error("byte compare miss");
  ctrl1_raz_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL2] [RL7]
    (rd_req && avs_address_i == WPC_OFF_CTRL1) |=> avs_readdata_o[23:4] == 20'h0 && avs_readdata_o[31:25] == 7'h0)
    else $error("ctrl1 reserved bits set");
  ctrl0_raz_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL2]
    (rd_req && avs_address_i == WPC_OFF_CTRL0) |=> avs_readdata_o[7:4] == 4'h0 && avs_readdata_o[9] == 1'b0)
    else $error("ctrl0 reserved bits set");
  linked_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL6] [RL9]
    (ctrl0.value_compare_enable && ctrl0.linked_comparator_index && !a1) |-> !hit0) else $error("linked addr ignored");
  bus_answer_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o) else $error("no answer");
  irq_level_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    irq_o == |(irq_status & irq_enable)) else $error("irq mismatch");
  cov_data_c: cover property (@(posedge mclk_i) hit0 && ctrl0.value_compare_enable);
  cov_linked_c: cover property (@(posedge mclk_i) hit0 && ctrl0.linked_comparator_index);
  cov_range_c: cover property (@(posedge mclk_i) hit1 && mask1 != 32'h0);
  cov_set_clear_c: cover property (@(posedge mclk_i) hit0 && rd_req && avs_address_i == WPC_OFF_CTRL0);
endmodule // wpc_top
`default_nettype wire

// [test/wpc_cpu_model.sv]
/*
  Processor access feed model: replays each requested access for one cycle.
  Assumes the bench raises req_i.valid for one clock per access.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_cpu_model
  import wpc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire wpc_access_t req_i,
  output wpc_access_t acc_o
);
  // Idle bus toggles so a stale address or data can never look like a hit
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      acc_o <= '0;
    else if (req_i.valid)
      acc_o <= req_i;
    else
      acc_o <= '{valid: 1'b0, kind: WPC_KIND_FETCH, addr: ~acc_o.addr, data: ~acc_o.data};
  end
endmodule // wpc_cpu_model
`default_nettype wire

// [test/tb_wpc_top.sv]
/*
  Self-checking bench for the watchpoint comparator control block.
  Assumes the Avalon-MM slave answers with one low waitrequest cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_wpc_top;
  import wpc_pkg::*;
  logic mclk_i = 0;
  logic rstn_i = 0;
  logic [3:0] avs_address_i = '0;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic [1:0] match_pulse_o;
  logic irq_o;
  wpc_access_t req = '0;
  wpc_access_t acc;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 95;
  logic [33:0] notes[$];
  logic [1:0] pulses[$];
  logic [3:0] codes [5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [31:0] a, v;
  logic hit;

  wpc_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .acc_i(acc),
    .match_pulse_o(match_pulse_o), .irq_o(irq_o));
  wpc_cpu_model u_cpu (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req), .acc_o(acc));

  always #20 mclk_i = ~mclk_i;

  task conclude;
    if (notes.size() != 0 || pulses.size() != 0)
      check("pending notes", 34'h0, 34'(notes.size() + pulses.size()));
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low, then one idle edge
  task bus(input logic [3:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= ad;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      check("waitrequest", 34'h0, 34'h1);
      conclude();
    end
    avs_read_i <= 0;
    avs_write_i <= 0;
    @(posedge mclk_i);
  endtask

  task wr(input logic [3:0] ad, input logic [31:0] d);
    bus(ad, 1'b1, d);
  endtask

  task rd(input logic [3:0] ad, input logic [33:0] exp);
    notes.push_back(exp);
    bus(ad, 1'b0, '0);
  endtask

  // The expected pulse is noted before the feed shows the access; a note left over means a lost pulse
  task access(input wpc_kind_t k, input logic [31:0] ad, input logic [31:0] d, input logic [1:0] pexp);
    if (pexp != 2'h0)
      pulses.push_back(pexp);
    req <= '{valid: 1'b1, kind: k, addr: ad, data: d};
    @(posedge mclk_i);
    req.valid <= 1'b0;
    repeat (3) @(posedge mclk_i);
    if (pulses.size() != 0) begin
      check("match pulse", 34'(pexp), 34'h0);
      pulses.delete();
    end
  endtask

  task vcase(input logic [1:0] sz, input logic lnk, input logic [31:0] ad, dt, input logic h);
    logic [31:0] c;
    c = {19'h0, lnk, sz, 1'b0, 1'b1, 4'h0, WPC_ACT_RW};
    wr(WPC_OFF_CTRL0, c);
    access(WPC_KIND_WRITE, ad, dt, {1'b0, h});
    rd(WPC_OFF_CTRL0, {9'h0, h, 24'h0} | 34'(c));
  endtask

  task irqchk(input logic exp);
    repeat (2) @(posedge mclk_i);
    check("irq", 34'(exp), 34'(irq_o));
  endtask

  // Read answers are taken at the edge that samples waitrequest low
  always @(posedge mclk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (notes.size() > 0)
        check("readdata", notes.pop_front(), {avs_response_o, avs_readdata_o});
      else
        check("unexpected read", 34'h0, 34'h1);
    end
  end

  // Every pulse must have been noted by the access that caused it
  always @(posedge mclk_i) begin
    if (rstn_i && match_pulse_o != 2'h0) begin
      if (pulses.size() > 0)
        check("match pulse", 34'(pulses.pop_front()), 34'(match_pulse_o));
      else
        check("unexpected pulse", 34'h0, 34'(match_pulse_o));
    end
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1;
    @(posedge mclk_i);
    rd(WPC_OFF_CTRL0, 34'h0);
    rd(4'h9, {2'b10, 32'h0});
    wr(WPC_OFF_CTRL0, 32'hffff_fff7);
    rd(WPC_OFF_CTRL0, 34'h1d07);
    avs_byteenable_i <= 4'h1;
    wr(WPC_OFF_CTRL0, 32'h0);
    avs_byteenable_i <= 4'h6;
    wr(WPC_OFF_COMP0, 32'hffff_ffff);
    avs_byteenable_i <= 4'hf;
    rd(WPC_OFF_CTRL0, 34'h1d00);
    rd(WPC_OFF_COMP0, 34'h00ff_ff00);
    wr(WPC_OFF_CTRL1, 32'hffff_fff7);
    rd(WPC_OFF_CTRL1, 34'h7);
    $display("test registers done");
    foreach (codes[i]) begin
      for (int j = 0; j < 3; j++) begin
        a = $random(seed);
        hit = (codes[i] == 4'h4 && j == 0) || (codes[i] == 4'h5 && j == 1) ||
          (codes[i] == 4'h6 && j == 2) || (codes[i] == 4'h7 && j != 0);
        wr(WPC_OFF_COMP0, a);
        wr(WPC_OFF_COMP1, a);
        wr(WPC_OFF_CTRL0, {28'h0, codes[i]});
        wr(WPC_OFF_CTRL1, {28'h0, codes[i]});
        access(wpc_kind_t'(j), a + 32'h4, 32'h0, 2'h0);
        access(wpc_kind_t'(j), a, $random(seed), {hit, hit});
        rd(WPC_OFF_CTRL0, {9'h0, hit, 20'h0, codes[i]});
        rd(WPC_OFF_CTRL1, {9'h0, hit, 20'h0, codes[i]});
        rd(WPC_OFF_CTRL0, {30'h0, codes[i]});
      end
    end
    $display("test action select done");
    v = $random(seed);
    a = $random(seed);
    wr(WPC_OFF_CTRL1, 32'h0);
    wr(WPC_OFF_COMP0, v);
    wr(WPC_OFF_COMP1, a);
    wr(WPC_OFF_MASK1, 32'h4);
    rd(WPC_OFF_MASK1, 34'h4);
    vcase(WPC_SZ_BYTE, 0, a, {~v[31:8], v[7:0]}, 1);
    vcase(WPC_SZ_HALF, 0, a, {~v[31:16], v[15:0]}, 1);
    vcase(WPC_SZ_HALF, 0, a, {v[31:8], ~v[7:0]}, 0);
    vcase(WPC_SZ_WORD, 0, a, {~v[31], v[30:0]}, 0);
    vcase(WPC_SZ_WORD, 0, v, ~v, 0);
    vcase(WPC_SZ_WORD, 1, {a[31:4], ~a[3:0]}, v, 1);
    vcase(WPC_SZ_WORD, 1, a ^ 32'h10, v, 0);
    $display("test value compare done");
    wr(WPC_OFF_IRQ_CLEAR, 32'h3);
    rd(WPC_OFF_IRQ_STATUS, 34'h0);
    wr(WPC_OFF_IRQ_ENABLE, 32'h1);
    irqchk(1'b0);
    wr(WPC_OFF_CTRL0, {28'h0, WPC_ACT_FETCH});
    access(WPC_KIND_FETCH, v, 32'h0, 2'h1);
    irqchk(1'b1);
    rd(WPC_OFF_IRQ_STATUS, 34'h1);
    wr(WPC_OFF_IRQ_ENABLE, 32'h0);
    irqchk(1'b0);
    wr(WPC_OFF_IRQ_ENABLE, 32'h1);
    irqchk(1'b1);
    wr(WPC_OFF_IRQ_CLEAR, 32'h1);
    irqchk(1'b0);
    rd(WPC_OFF_IRQ_STATUS, 34'h0);
    rd(WPC_OFF_IRQ_CLEAR, 34'h0);
    $display("test interrupt done");
    conclude();
  end
endmodule // tb_wpc_top
`default_nettype wire
